// [verilog/target_status_pkg.sv]
// Contract
// [RULE_01] Power indicator lit while the user system has power, dark otherwise.
// [RULE_02] With several supply terminals, power indicator lights only when all are powered.
// [RULE_03] Clock indicator lit if main or sub clock oscillates; off when both stopped.
// [RULE_04] Reset indicator lit while target is in reset or user reset is low.
// [RULE_05] Run indicator lit while the user program executes, off once halted.
// [RULE_06] Maskable interrupt acknowledge fetches number and level from the two info locations.
// [RULE_07] Any read of either info location clears the top enabled interrupt request.
// [RULE_08] Warning lights on an info-location read that is not an interrupt acknowledge.
// [RULE_09] User system keeps wait-request and hold-request high at startup in external modes.
// [RULE_10] Warning stays latched until the host clears it or the monitor resets.
`default_nettype none
package target_status_pkg;
  localparam int ADDR_W = 20;
  localparam logic [19:0] INFO_ADDR_LO = 20'h00000;
  localparam logic [19:0] INFO_ADDR_HI = 20'h00001;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_EVENT = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0C;
  localparam logic [7:0] OFF_WARN_CLR = 8'h10;
  localparam int CTRL_WARN_EN = 0;
  localparam int WARN_CLR_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h00000001;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam int EV_WRONG_READ = 0;
  localparam int EV_POWER_LOSS = 1;
  localparam int EV_CLOCK_LOSS = 2;
  localparam int EV_RESET_ENTRY = 3;
  localparam int EV_W = 4;
  localparam int CORE_CLK_MHZ = 200;
  localparam int CLK_TIMEOUT_NS = 100000;
  localparam int CLK_TIMEOUT_CYCLES = CLK_TIMEOUT_NS * CORE_CLK_MHZ / 1000;
endpackage
`default_nettype wire

// [verilog/target_status_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module target_status_monitor #(
  parameter int SUPPLY_N = 2,
  parameter int TIMEOUT_CYCLES = target_status_pkg::CLK_TIMEOUT_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [SUPPLY_N-1:0] supplyOk,
  input wire logic mainClk,
  input wire logic subClk,
  input wire logic mcuInReset,
  input wire logic userReset_n,
  input wire logic progRunning,
  input wire logic busRead,
  input wire logic intAck,
  input wire logic [19:0] busAddr,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  output logic ledPower,
  output logic ledClock,
  output logic ledReset,
  output logic ledRun,
  output logic ledWarning,
  output logic intReqClear,
  output logic ackFetch,
  output logic irq
);
  localparam int PIN_W = SUPPLY_N + 27;
  localparam int EV_W_LOCAL = target_status_pkg::EV_W;
  // The user reset pin idles high, so its stages start high and no false reset edge follows reset.
  localparam logic [PIN_W-1:0] PIN_IDLE = {{(PIN_W-24){1'b0}}, 1'b1, 23'h000000};

  logic [PIN_W-1:0] pinRaw;
  logic [PIN_W-1:0] sync1;
  logic [PIN_W-1:0] sync2;
  logic [PIN_W-1:0] sync3;
  logic [PIN_W-1:0] pinFilt;
  logic [SUPPLY_N-1:0] supplyF;
  logic mainClkF;
  logic subClkF;
  logic inResetF;
  logic userResetF_n;
  logic runF;
  logic readF;
  logic ackF;
  logic [19:0] addrF;
  logic readPrev;
  logic [1:0] clkPrev;
  logic [1:0] clkAlive;
  logic [31:0] clkCount [2];
  logic [31:0] ctrl;
  logic [EV_W_LOCAL-1:0] events;
  logic [EV_W_LOCAL-1:0] mask;
  logic warnLatch;
  logic powerPrev;
  logic clockPrev;
  logic resetPrev;

  // A pin change counts only once the second and third stages agree.
  assign pinRaw = {
    supplyOk,
    mainClk,
    subClk,
    mcuInReset,
    userReset_n,
    progRunning,
    busRead,
    intAck,
    busAddr
  };
  assign {
    supplyF,
    mainClkF,
    subClkF,
    inResetF,
    userResetF_n,
    runF,
    readF,
    ackF,
    addrF
  } = pinFilt;

  // Only the second stage reads the first, which may still be settling.
  always_ff @(posedge core_clk)
  begin
    if (rst)
      sync1 <= PIN_IDLE;
    else
      sync1 <= pinRaw;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      sync2 <= PIN_IDLE;
    else
      sync2 <= sync1;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      sync3 <= PIN_IDLE;
    else
      sync3 <= sync2;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      pinFilt <= PIN_IDLE;
    else
      pinFilt <= (sync2 & sync3) | (pinFilt & (sync2 | sync3));
  end

  wire powerOk = &supplyF; // RULE_01 RULE_02
  wire clockOk = |clkAlive; // RULE_03
  wire resetOn = inResetF | ~userResetF_n; // RULE_04
  wire readStart = readF & ~readPrev;
  wire infoHit = (addrF == target_status_pkg::INFO_ADDR_LO) ||
                 (addrF == target_status_pkg::INFO_ADDR_HI);
  wire infoRead = readStart & infoHit;
  wire wrongRead = infoRead & ~ackF &
                   ctrl[target_status_pkg::CTRL_WARN_EN]; // RULE_08

  // A stopped clock is seen as no edge for the whole timeout window; the window must cover the slow sub clock.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_clk
      wire clkIn = (gi == 0) ? mainClkF : subClkF;
      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          clkPrev[gi] <= 1'b0;
          clkCount[gi] <= 32'h00000000;
          clkAlive[gi] <= 1'b0;
        end
        else
        begin
          clkPrev[gi] <= clkIn;
          if (clkIn != clkPrev[gi])
          begin
            clkCount[gi] <= 32'h00000000;
            clkAlive[gi] <= 1'b1; // RULE_03
          end
          else if (clkCount[gi] >= 32'(TIMEOUT_CYCLES - 1))
            clkAlive[gi] <= 1'b0; // RULE_03
          else
            clkCount[gi] <= clkCount[gi] + 32'h00000001;
        end
      end
    end
  endgenerate

  wire wrCtrl = regWr && (regAddr == target_status_pkg::OFF_CTRL);
  wire wrEvent = regWr && (regAddr == target_status_pkg::OFF_EVENT);
  wire wrMask = regWr && (regAddr == target_status_pkg::OFF_MASK);
  wire wrWarnClr = regWr && (regAddr == target_status_pkg::OFF_WARN_CLR) &&
                   regWrData[target_status_pkg::WARN_CLR_BIT];
  wire [EV_W_LOCAL-1:0] eventSet = {
    resetOn & ~resetPrev,
    clockPrev & ~clockOk,
    powerPrev & ~powerOk,
    wrongRead
  };
  wire [EV_W_LOCAL-1:0] eventClr = wrEvent ?
    regWrData[EV_W_LOCAL-1:0] :
    {EV_W_LOCAL{1'b0}};

  wire [31:0] statusWord = {
    27'h0000000,
    ledWarning,
    ledRun,
    ledReset,
    ledClock,
    ledPower
  };
  wire selCtrl = (regAddr == target_status_pkg::OFF_CTRL);
  wire selStatus = (regAddr == target_status_pkg::OFF_STATUS);
  wire selEvent = (regAddr == target_status_pkg::OFF_EVENT);
  wire selMask = (regAddr == target_status_pkg::OFF_MASK);

  wire [31:0] readMux =
    selCtrl ? ctrl :
    selStatus ? statusWord :
    selEvent ? {28'h0000000, events} :
    selMask ? {28'h0000000, mask} : 32'h00000000;

  // A new event in the clearing cycle survives the clear.
  wire [EV_W_LOCAL-1:0] next_events = (events & ~eventClr) | eventSet;
  wire next_warnLatch = wrongRead | (warnLatch & ~wrWarnClr); // RULE_10
  wire [31:0] next_ctrl = wrCtrl ? regWrData : ctrl;
  wire [EV_W_LOCAL-1:0] next_mask = wrMask ? regWrData[EV_W_LOCAL-1:0] : mask;
  wire next_irq = |(next_events & mask);
  // Idle cycles return zero so that a stale word is never taken for an answer.
  wire [31:0] next_rdData = regRd ? readMux : 32'h00000000;

  // Edge history for the event detectors; each starts from the reset value of its source.
  always_ff @(posedge core_clk)
  begin
    if (rst)
      readPrev <= 1'b0;
    else
      readPrev <= readF;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      powerPrev <= 1'b0;
    else
      powerPrev <= powerOk;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      clockPrev <= 1'b0;
    else
      clockPrev <= clockOk;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      resetPrev <= 1'b0;
    else
      resetPrev <= resetOn;
  end

  // Register state.
  always_ff @(posedge core_clk)
  begin
    if (rst)
      ctrl <= target_status_pkg::CTRL_RESET;
    else
      ctrl <= next_ctrl;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      mask <= target_status_pkg::MASK_RESET;
    else
      mask <= next_mask;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      events <= '0;
    else
      events <= next_events;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      warnLatch <= 1'b0;
    else
      warnLatch <= next_warnLatch; // RULE_10
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      regRdData <= 32'h00000000;
    else
      regRdData <= next_rdData;
  end

  // Lamps and pulses are registered so that decode glitches never reach the pins.
  always_ff @(posedge core_clk)
  begin
    if (rst)
      ledPower <= 1'b0;
    else
      ledPower <= powerOk; // RULE_01 RULE_02
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      ledClock <= 1'b0;
    else
      ledClock <= clockOk; // RULE_03
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      ledReset <= 1'b0;
    else
      ledReset <= resetOn; // RULE_04
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      ledRun <= 1'b0;
    else
      ledRun <= runF; // RULE_05
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      ledWarning <= 1'b0;
    else
      ledWarning <= next_warnLatch; // RULE_08 RULE_10
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      intReqClear <= 1'b0;
    else
      intReqClear <= infoRead; // RULE_07
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      ackFetch <= 1'b0;
    else
      ackFetch <= infoRead & ackF; // RULE_06
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= next_irq;
  end
endmodule
`default_nettype wire

// [tb/target_status_monitor_props.sv]
`timescale 1ns/100ps
`default_nettype none
module target_status_monitor_props #(parameter int SUPPLY_N = 2) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [SUPPLY_N-1:0] supplyOk,
  input wire logic mcuInReset,
  input wire logic userReset_n,
  input wire logic progRunning,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic ledPower,
  input wire logic ledReset,
  input wire logic ledRun,
  input wire logic ledWarning,
  input wire logic intReqClear,
  input wire logic ackFetch
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Eight stable samples leave room for the pin filter and the lamp register.
  wire warnClr = regWr && regAddr == target_status_pkg::OFF_WARN_CLR && regWrData[0];
  a_power_all_on: assert property ((&supplyOk)[*8] |-> ledPower) else $error("power dark");
  a_power_any_off: assert property ((!(&supplyOk))[*8] |-> !ledPower) else $error("power lit");
  a_reset_lit: assert property ((mcuInReset || !userReset_n)[*8] |-> ledReset) else $error("reset dark");
  a_reset_dark: assert property ((!mcuInReset && userReset_n)[*8] |-> !ledReset) else $error("reset lit");
  a_run_follows: assert property (progRunning[*8] |-> ledRun) else $error("run dark");
  a_warn_held: assert property (ledWarning && !warnClr |=> ledWarning) else $error("warn lost");
  a_clear_pulse: assert property (intReqClear |=> !intReqClear) else $error("clear long");
  a_ack_is_read: assert property (ackFetch |-> intReqClear) else $error("ack alone");
  a_wrong_warns: assert property (intReqClear && !ackFetch |-> ##[0:1] ledWarning) else $error("no warn");
  cover property (ackFetch);
  cover property (intReqClear && !ackFetch);
  cover property ($fell(ledWarning));
endmodule
bind target_status_monitor target_status_monitor_props #(.SUPPLY_N(SUPPLY_N)) u_props (.*);
`default_nettype wire

// [tb/target_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Target oscillators; a stopped clock stands still. No wait or hold request is modelled.
module target_model (
  input wire logic mainOn,
  input wire logic subOn,
  output logic mainClk = 1'b0,
  output logic subClk = 1'b0
);
  always #20 mainClk = mainOn ? ~mainClk : mainClk;
  always #31 subClk = subOn ? ~subClk : subClk;
endmodule
`default_nettype wire

// [tb/target_status_monitor_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module target_status_monitor_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] supplyOk = 2'h0;
  logic mainOn = 1'b0;
  logic subOn = 1'b0;
  logic mcuInReset = 1'b0;
  logic userReset_n = 1'b1;
  logic progRunning = 1'b0;
  logic busRead = 1'b0;
  logic intAck = 1'b0;
  logic [19:0] busAddr = 20'h00000;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h00000000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  wire mainClk, subClk, ledPower, ledClock, ledReset, ledRun, ledWarning, intReqClear, ackFetch, irq;
  wire [31:0] regRdData;
  int fail_count = 0;
  int n_tests = 0;
  int nClr = 0;
  int nAck = 0;
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) nClr <= nClr + int'(intReqClear === 1'b1);
  always @(posedge core_clk) nAck <= nAck + int'(ackFetch === 1'b1);
  target_model u_model (.mainOn(mainOn), .subOn(subOn), .mainClk(mainClk), .subClk(subClk));
  target_status_monitor #(.SUPPLY_N(2), .TIMEOUT_CYCLES(50)) u_dut (.core_clk(core_clk), .rst(rst),
    .supplyOk(supplyOk), .mainClk(mainClk), .subClk(subClk), .mcuInReset(mcuInReset), .userReset_n(userReset_n),
    .progRunning(progRunning), .busRead(busRead), .intAck(intAck), .busAddr(busAddr), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .ledPower(ledPower),
    .ledClock(ledClock), .ledReset(ledReset), .ledRun(ledRun), .ledWarning(ledWarning),
    .intReqClear(intReqClear), .ackFetch(ackFetch), .irq(irq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1;
    chk(regRdData, e);
  endtask
  // Address and acknowledge stay put after the strobe drops, as the pin filter needs.
  task automatic busRd(input logic [19:0] a, input logic ack);
    @(posedge core_clk);
    busAddr <= a;
    intAck <= ack;
    busRead <= 1'b1;
    repeat (6) @(posedge core_clk);
    busRead <= 1'b0;
    tick(8);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #20000;
    fail_count++;
    print_verdict;
  end
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    tick(1);
    chk({ledWarning, ledRun, ledReset, ledClock, ledPower}, 32'h00000000);
    for (int v = 0; v < 4; v++)
    begin
      @(posedge core_clk) supplyOk <= v[1:0];
      tick(10);
      chk(ledPower, v == 3);
      @(posedge core_clk) {mcuInReset, userReset_n} <= {v[0], v[1]};
      tick(10);
      chk(ledReset, v != 2);
    end
    for (int v = 1; v >= 0; v--)
    begin
      @(posedge core_clk) progRunning <= v[0];
      tick(10);
      chk(ledRun, v[0]);
    end
    for (int v = 2; v >= 0; v--)
    begin
      @(posedge core_clk) {mainOn, subOn} <= v[1:0];
      tick(80);
      chk(ledClock, v != 0);
    end
    wr(target_status_pkg::OFF_EVENT, 32'h0000000F);
    busRd(20'h00000, 1'b1);
    chk({nAck[3:0], ledWarning}, 32'h00000002);
    busRd(20'h00002, 1'b0);
    chk(nClr, 1);
    busRd(20'h00001, 1'b0);
    chk({nClr[3:0], ledWarning, irq}, 32'h0000000A);
    rd(target_status_pkg::OFF_STATUS, 32'h00000015);
    rd(target_status_pkg::OFF_EVENT, 32'h00000001);
    wr(target_status_pkg::OFF_MASK, 32'h00000001);
    chk(irq, 1'b1);
    wr(target_status_pkg::OFF_WARN_CLR, 32'h00000001);
    chk(ledWarning, 1'b0);
    wr(target_status_pkg::OFF_EVENT, 32'h00000001);
    chk(irq, 1'b0);
    rd(8'h20, 32'h00000000);
    rd(target_status_pkg::OFF_CTRL, 32'h00000001);
    print_verdict;
  end
endmodule
`default_nettype wire
